/* File: tpec_top.sv */
// Tamper pin control with Avalon-MM register slave
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tpec_top
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic tamper_pin_in,
	output logic tamper_pin_out,
	output logic tamper_pin_oe,
	output logic tamper_pull_en,
	input wire logic low_power_io_lock,
	output logic tamper_irq,
	output logic tamper_wake
);
	tpec_pkg::tpec_cfg_t cfg;
	tpec_pkg::tpec_cfg_t next_cfg;
	logic pin_event_flag;
	logic tamper_common_flag;
	logic tamper_interrupt_enable;
	logic tamper_detect_enable;
	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic pin_edge;
	logic served;
	logic wr_hit;
	logic [7:0] wdat;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	// One wait cycle per access, waitrequest from a flop
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			served <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
		else if ((avs_read || avs_write) && !served)
		begin
			served <= 1'b1;
			avs_waitrequest <= 1'b0;
		end
		else
		begin
			served <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
	end

	always_comb
	begin
		wr_hit = avs_write && served;
		wdat = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
	end

	// Pin synchroniser
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end
		else
		begin
			sync_a <= tamper_pin_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	always_comb
	begin
		if (cfg.edge_fall)
			pin_edge = sync_c && !sync_b;
		else
			pin_edge = !sync_c && sync_b;
	end

	// Configuration register, still written under the lock
	always_comb
	begin
		next_cfg = cfg;
		if (wr_hit && avs_byteenable[0]
			&& hit(avs_address, tpec_pkg::OFS_PIN_CTRL))
		begin
			next_cfg.out_level = wdat[tpec_pkg::BIT_OUT];
			next_cfg.dir_out = wdat[tpec_pkg::BIT_DIR];
			next_cfg.pull_en = wdat[tpec_pkg::BIT_PULL];
			next_cfg.edge_fall = wdat[tpec_pkg::BIT_EDGE];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			cfg <= {tpec_pkg::RST_PIN_CTRL[tpec_pkg::BIT_OUT],
				tpec_pkg::RST_PIN_CTRL[tpec_pkg::BIT_DIR],
				tpec_pkg::RST_PIN_CTRL[tpec_pkg::BIT_PULL],
				tpec_pkg::RST_PIN_CTRL[tpec_pkg::BIT_EDGE]};
		else
			cfg <= next_cfg;
	end

	// Pin drive, held while the lock is up
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			tamper_pin_out <= 1'b0;
			tamper_pin_oe <= 1'b0;
			tamper_pull_en <= 1'b0;
		end
		else if (!low_power_io_lock)
		begin
			tamper_pin_out <= next_cfg.out_level;
			tamper_pin_oe <= next_cfg.dir_out;
			tamper_pull_en <= next_cfg.pull_en && !next_cfg.dir_out;
		end
	end

	// Per-pin sticky event flag
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pin_event_flag <= 1'b0;
		else if (pin_edge && tamper_detect_enable)
			pin_event_flag <= 1'b1;
		else if (wr_hit && avs_byteenable[0] && hit(avs_address, tpec_pkg::OFS_PIN_CTRL)
			&& !wdat[tpec_pkg::BIT_EVENT])
			pin_event_flag <= 1'b0;
	end

	// Common flag, write one to clear
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			tamper_common_flag <= 1'b0;
		else if (pin_edge && tamper_detect_enable && !pin_event_flag)
			tamper_common_flag <= 1'b1;
		else if (wr_hit && avs_byteenable[0] && hit(avs_address, tpec_pkg::OFS_INT_STATUS)
			&& wdat[tpec_pkg::BIT_COMMON])
			tamper_common_flag <= 1'b0;
	end

	// Enables
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			tamper_interrupt_enable <= 1'b0;
			tamper_detect_enable <= 1'b0;
		end
		else if (wr_hit && avs_byteenable[0])
		begin
			if (hit(avs_address, tpec_pkg::OFS_INT_CTRL))
				tamper_interrupt_enable <= wdat[tpec_pkg::BIT_INT_EN];
			if (hit(avs_address, tpec_pkg::OFS_DETECT_CTRL))
				tamper_detect_enable <= wdat[tpec_pkg::BIT_DETECT_EN];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			tamper_irq <= 1'b0;
			tamper_wake <= 1'b0;
		end
		else
		begin
			tamper_irq <= tamper_common_flag && tamper_interrupt_enable;
			tamper_wake <= tamper_common_flag && tamper_interrupt_enable;
		end
	end

	// Read data
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			avs_readdata <= tpec_pkg::RST_WORD;
		else if (avs_read && !served)
		begin
			avs_readdata <= tpec_pkg::RST_WORD;
			unique case (avs_address)
				tpec_pkg::OFS_PIN_CTRL:
				begin
					avs_readdata[tpec_pkg::BIT_OUT] <= cfg.out_level;
					avs_readdata[tpec_pkg::BIT_DIR] <= cfg.dir_out;
					avs_readdata[tpec_pkg::BIT_IN] <= sync_b;
					avs_readdata[tpec_pkg::BIT_PULL] <= cfg.pull_en;
					avs_readdata[tpec_pkg::BIT_EDGE] <= cfg.edge_fall;
					avs_readdata[tpec_pkg::BIT_EVENT] <= pin_event_flag;
				end
				tpec_pkg::OFS_DETECT_CTRL:
					avs_readdata[tpec_pkg::BIT_DETECT_EN] <= tamper_detect_enable;
				tpec_pkg::OFS_INT_CTRL:
					avs_readdata[tpec_pkg::BIT_INT_EN] <= tamper_interrupt_enable;
				tpec_pkg::OFS_INT_STATUS:
					avs_readdata[tpec_pkg::BIT_COMMON] <= tamper_common_flag;
				default:
					avs_readdata <= tpec_pkg::RST_WORD;
			endcase
		end
	end

	// Steps that the checks below are built from
	sequence s_edge_armed;
		pin_edge && tamper_detect_enable;
	endsequence

	sequence s_rise_armed;
		tamper_detect_enable && !cfg.edge_fall && !sync_c && sync_b;
	endsequence

	sequence s_fall_armed;
		tamper_detect_enable && cfg.edge_fall && sync_c && !sync_b;
	endsequence

	sequence s_flag_clear;
		wr_hit && avs_byteenable[0] && hit(avs_address, tpec_pkg::OFS_PIN_CTRL)
			&& !avs_writedata[tpec_pkg::BIT_EVENT] && !pin_edge;
	endsequence

	sequence s_common_clear;
		wr_hit && avs_byteenable[0] && hit(avs_address, tpec_pkg::OFS_INT_STATUS)
			&& avs_writedata[tpec_pkg::BIT_COMMON] && !pin_edge;
	endsequence

	sequence s_pin_read_answer;
		avs_read && !avs_waitrequest && hit(avs_address, tpec_pkg::OFS_PIN_CTRL);
	endsequence

	// Edge selection and sticky flag
	AST_EVENT_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_edge_armed |=> pin_event_flag)
		else $error("event flag not set after edge");

	AST_RISE: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_rise_armed |=> pin_event_flag)
		else $error("rising edge missed");

	AST_FALL: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_fall_armed |=> pin_event_flag)
		else $error("falling edge missed");

	AST_RISE_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
		!pin_event_flag && !cfg.edge_fall && !sync_b |=> !pin_event_flag)
		else $error("event without rising edge");

	AST_FALL_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
		!pin_event_flag && cfg.edge_fall && sync_b |=> !pin_event_flag)
		else $error("event without falling edge");

	AST_NO_DETECT: assert property (@(posedge core_clk) disable iff (sys_rst)
		!tamper_detect_enable && !pin_event_flag |=> !pin_event_flag)
		else $error("event set while detection off");

	AST_NO_REFIRE: assert property (@(posedge core_clk) disable iff (sys_rst)
		pin_event_flag |=> !$rose(tamper_common_flag))
		else $error("ignored edge raised common flag");

	AST_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
		pin_event_flag && !wr_hit |=> pin_event_flag)
		else $error("event flag lost without write");

	AST_WRITE_ONE: assert property (@(posedge core_clk) disable iff (sys_rst)
		!pin_event_flag && !pin_edge |=> !pin_event_flag)
		else $error("event flag set without edge");

	AST_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_flag_clear |=> !pin_event_flag)
		else $error("event flag not cleared by zero");

	// Register map
	AST_RESERVED: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_pin_read_answer |-> !avs_readdata[7] && !avs_readdata[1]
			&& avs_readdata[31:8] == 24'h000000)
		else $error("reserved bits not zero");

	AST_IN_BIT: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_pin_read_answer |-> avs_readdata[tpec_pkg::BIT_IN] == $past(sync_b))
		else $error("input bit differs from pin");

	// Pin drive and lock
	AST_DRIVE: assert property (@(posedge core_clk) disable iff (sys_rst)
		tamper_pin_oe && !$past(low_power_io_lock) |-> tamper_pin_out == cfg.out_level)
		else $error("pin level differs from out bit");

	AST_DIR: assert property (@(posedge core_clk) disable iff (sys_rst)
		!$past(low_power_io_lock) |-> tamper_pin_oe == cfg.dir_out)
		else $error("pin direction differs from dir bit");

	AST_PULL: assert property (@(posedge core_clk) disable iff (sys_rst)
		tamper_pull_en |-> !tamper_pin_oe)
		else $error("pull enabled while output");

	AST_PULL_CFG: assert property (@(posedge core_clk) disable iff (sys_rst)
		!$past(low_power_io_lock) |-> tamper_pull_en == (cfg.pull_en && !cfg.dir_out))
		else $error("pull differs from pull bit");

	AST_LOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
		low_power_io_lock |=> $stable({tamper_pin_out, tamper_pin_oe, tamper_pull_en}))
		else $error("pin changed under lock");

	AST_LOCK_REG: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_hit && avs_byteenable[0] && hit(avs_address, tpec_pkg::OFS_PIN_CTRL)
			|=> cfg.dir_out == $past(avs_writedata[tpec_pkg::BIT_DIR]))
		else $error("control write lost");

	// Interrupt path
	AST_IRQ: assert property (@(posedge core_clk) disable iff (sys_rst)
		tamper_common_flag && tamper_interrupt_enable |=> tamper_irq)
		else $error("interrupt not raised");

	AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
		!(tamper_common_flag && tamper_interrupt_enable) |=> !tamper_irq)
		else $error("interrupt without enabled flag");

	AST_WAKE: assert property (@(posedge core_clk) disable iff (sys_rst)
		tamper_common_flag && tamper_interrupt_enable |=> tamper_wake)
		else $error("wake not raised");

	AST_WAKE_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
		!(tamper_common_flag && tamper_interrupt_enable) |=> !tamper_wake)
		else $error("wake without enabled flag");

	AST_COMMON: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(pin_event_flag) |-> tamper_common_flag)
		else $error("common flag not set with event");

	AST_COMMON_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
		tamper_common_flag && !wr_hit |=> tamper_common_flag)
		else $error("common flag lost without write");

	AST_COMMON_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_common_clear |=> !tamper_common_flag)
		else $error("common flag not cleared");

	// Synchroniser
	AST_SYNC: assert property (@(posedge core_clk) disable iff (sys_rst)
		!$past(sys_rst) && !$past(sys_rst, 2) |-> sync_b == $past(tamper_pin_in, 2))
		else $error("synchroniser delay wrong");
endmodule

/* File: tpec_pkg.sv */
// Constants and types for the tamper pin event control block
// Behaviour
// - Direction one drives pin at output level
// - Input bit reads present pin level
// - Pull enable acts only while input
// - Edge select: zero rising, one falling
// - Qualifying edge sets sticky event flag
// - Event flag cleared by zero only
// - Pin control bits seven and one read zero
// - Pin drive frozen while lock asserted
// - Common flag set, interrupts when enabled
// - Detection only while detect enable set
package tpec_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam logic [3:0] OFS_PIN_CTRL = 4'h0;
	localparam logic [3:0] OFS_DETECT_CTRL = 4'h4;
	localparam logic [3:0] OFS_INT_CTRL = 4'h8;
	localparam logic [3:0] OFS_INT_STATUS = 4'hC;
	localparam int BIT_OUT = 6;
	localparam int BIT_DIR = 5;
	localparam int BIT_IN = 4;
	localparam int BIT_PULL = 3;
	localparam int BIT_EDGE = 2;
	localparam int BIT_EVENT = 0;
	localparam int BIT_DETECT_EN = 0;
	localparam int BIT_INT_EN = 1;
	localparam int BIT_COMMON = 0;
	localparam logic [7:0] RST_PIN_CTRL = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef struct packed {
		logic out_level;
		logic dir_out;
		logic pull_en;
		logic edge_fall;
	} tpec_cfg_t;

	typedef struct packed {
		logic pin_out;
		logic pin_oe;
		logic pull_en;
	} tpec_pin_t;
endpackage

/* File: tpec_pin_model.sv */
// External switch on the tamper pin with pull resistor
`timescale 1ns/1ps
module tpec_pin_model
(
	input wire logic core_clk,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic pull_en,
	input wire logic sw_on,
	input wire logic sw_level,
	output logic pin_level
);
	logic float_q = 1'b0;
	always @(posedge core_clk)
		float_q <= ~float_q;
	// Driven pin wins, then switch, then pull-up, else floating
	assign pin_level = pin_oe ? pin_out : sw_on ? sw_level : pull_en ? 1'b1 : float_q;
endmodule

/* File: testbench.sv */
// Self-checking bench for the tamper pin block
`timescale 1ns/1ps
`define CHK(a,b) begin checked++; if ((a)!==(b)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	logic core_clk = 0, sys_rst = 1, rd = 0, wr = 0, lock = 0, sw_lvl = 0, sw_on = 1;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, q, rdat;
	logic wq, p_out, p_oe, p_pull, irq, wake, pin;
	int err_total = 0, checked = 0;
	always #20 core_clk = ~core_clk;
	tpec_top dut(.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
		.avs_waitrequest(wq), .tamper_pin_in(pin), .tamper_pin_out(p_out),
		.tamper_pin_oe(p_oe), .tamper_pull_en(p_pull), .low_power_io_lock(lock),
		.tamper_irq(irq), .tamper_wake(wake));
	tpec_pin_model pm(.core_clk(core_clk), .pin_out(p_out), .pin_oe(p_oe), .pull_en(p_pull),
		.sw_on(sw_on), .sw_level(sw_lvl), .pin_level(pin));
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		@(posedge core_clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h0, d};
		do @(posedge core_clk); while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		`CHK(q, {24'h0, e})
	endtask
	task automatic pin_to(input logic v);
		@(posedge core_clk);
		sw_lvl <= v;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic t_regs;
		rchk(4'h0, 8'h00);
		bus(4'h1, 1'b1, 8'hFF);
		rchk(4'h1, 8'h00);
		bus(4'h0, 1'b1, 8'hFF);
		settle;
		rchk(4'h0, 8'h7C);
		`CHK({p_oe, p_out, p_pull}, 3'b110)
		bus(4'h0, 1'b1, 8'h20);
		settle;
		rchk(4'h0, 8'h20);
		`CHK({p_oe, p_out}, 2'b10)
		$display("regs done");
	endtask
	task automatic t_edges;
		bus(4'h0, 1'b1, 8'h08);
		bus(4'h4, 1'b1, 8'h01);
		bus(4'h8, 1'b1, 8'h02);
		`CHK(p_pull, 1'b1)
		pin_to(1'b1);
		rchk(4'h0, 8'h19);
		rchk(4'hC, 8'h01);
		`CHK({irq, wake}, 2'b11)
		pin_to(1'b0);
		pin_to(1'b1);
		bus(4'h0, 1'b1, 8'h09);
		rchk(4'h0, 8'h19);
		bus(4'h0, 1'b1, 8'h08);
		rchk(4'h0, 8'h18);
		bus(4'h8, 1'b1, 8'h00);
		settle;
		`CHK(irq, 1'b0)
		bus(4'hC, 1'b1, 8'h01);
		bus(4'h8, 1'b1, 8'h02);
		settle;
		`CHK(irq, 1'b0)
		$display("edges done");
	endtask
	task automatic t_fall;
		bus(4'h0, 1'b1, 8'h0C);
		pin_to(1'b0);
		rchk(4'h0, 8'h0D);
		bus(4'h0, 1'b1, 8'h0C);
		bus(4'h4, 1'b1, 8'h00);
		pin_to(1'b1);
		pin_to(1'b0);
		rchk(4'h0, 8'h0C);
		sw_on <= 1'b0;
		settle;
		rchk(4'h0, 8'h1C);
		$display("fall done");
	endtask
	task automatic t_lock;
		lock <= 1'b1;
		bus(4'h0, 1'b1, 8'h60);
		settle;
		`CHK({p_oe, p_pull}, 2'b01)
		rchk(4'h0, 8'h70);
		lock <= 1'b0;
		settle;
		`CHK({p_oe, p_out, p_pull}, 3'b110)
		$display("lock done");
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_edges;
		t_fall;
		t_lock;
		give_verdict;
	end
	initial
	begin
		#200000;
		err_total++;
		give_verdict;
	end
endmodule
